// ### src/cxe_exception_entry.sv
/*
 * Exception entry unit: interrupt sampling, abort handling, trap and
 * undefined decode, priority, entry, return and reset entry.
 * Assumes the core pulses instr_end once per executed instruction and
 * follows fetch_redirect; the interrupt lines are on the core clock.
 */
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module cxe_exception_entry
   import cxe_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic fast_int_n,
   input wire logic normal_int_n,
   input wire logic fetch_abort,
   input wire logic pipe_advance,
   input wire logic pipe_flush,
   input wire logic data_abort,
   input wire logic instr_end,
   input wire logic [31:0] instr_word,
   input wire logic [31:0] exec_pc,
   input wire logic [31:0] next_pc,
   input wire logic is_single_xfer,
   input wire logic is_swap,
   input wire logic is_block_xfer,
   input wire logic reg_wr_req,
   input wire logic base_wb_req,
   input wire logic psr_wr_en,
   input wire logic [31:0] psr_wr_data,
   input wire logic ret_restore,
   input wire logic [2:0] bank_sel,
   output logic reg_wr_en,
   output logic base_wb_en,
   output logic fetch_redirect,
   output logic [31:0] fetch_addr_r,
   output logic [31:0] current_status_word,
   output logic [31:0] bank_link_r,
   output logic [31:0] bank_saved_r,
   output logic mmu_enable,
   output logic align_fault_enable,
   output logic cache_enable,
   output logic wbuf_enable,
   output logic data_space_32,
   output logic big_endian,
   output logic tlb_flush,
   output logic cache_flush
);
   initial begin
      if (ADDR_W < 4) $error("ADDR_W below 4 cannot decode the register map");
   end

   typedef enum logic [1:0] {ST_RESET, ST_REXIT, ST_RUN, ST_CHAIN} cxe_state_e;
   cxe_state_e state_r;
   logic fast_sync_r, normal_sync_r;
   logic fetch_tag_r, exec_tag_r, dabt_seen_r;
   logic [31:0] current_status_word_r, cfg_r;
   logic [31:0] link_r [5];
   logic [31:0] saved_r [5];
   cxe_cause_e cause_r;
   logic [31:0] cur_pc_r;

   ////////////////////////////////////////////////////////////////////////
   // Interrupt synchronizers and pending terms
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fast_sync_r <= 1'b1;
         normal_sync_r <= 1'b1;
      end else begin
         fast_sync_r <= fast_int_n;
         normal_sync_r <= normal_int_n;
      end
   end

   logic privileged, fiq_pend, irq_pend, dabt_now;
   logic cop_instr, mcr_mrc_int, undef_hit, trap_hit, pabt_hit;
   assign privileged = current_status_word_r[4:0] != MODE_USR;
   assign fiq_pend = !current_status_word_r[PSR_F_BIT] && !fast_sync_r;
   assign irq_pend = !current_status_word_r[PSR_I_BIT] && !normal_sync_r;
   assign dabt_now = data_abort || dabt_seen_r;

   ////////////////////////////////////////////////////////////////////////
   // Instruction decode for traps
   assign cop_instr = (instr_word[27:24] == 4'hE) || (instr_word[27:25] == 3'h6);
   assign mcr_mrc_int = (instr_word[27:24] == 4'hE) && instr_word[4]
                        && (instr_word[11:8] == 4'hF) && !instr_word[19]
                        && privileged;
   assign undef_hit = (cop_instr && !mcr_mrc_int)
                      || ((instr_word[27:25] == 3'h3) && instr_word[4]);
   assign trap_hit = instr_word[27:24] == 4'hF;
   assign pabt_hit = exec_tag_r;

   ////////////////////////////////////////////////////////////////////////
   // Prefetch abort tag travels with the instruction
   always_ff @(posedge aclk) begin
      if (!aresetn || pipe_flush) begin
         fetch_tag_r <= 1'b0;
         exec_tag_r <= 1'b0;
      end else if (pipe_advance) begin
         fetch_tag_r <= fetch_abort;
         exec_tag_r <= fetch_tag_r;
      end else if (fetch_abort) begin
         fetch_tag_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register write gating under data abort
   always_ff @(posedge aclk) begin
      if (!aresetn || instr_end) begin
         dabt_seen_r <= 1'b0;
      end else if (data_abort) begin
         dabt_seen_r <= 1'b1;
      end
   end

   always_comb begin
      reg_wr_en = reg_wr_req;
      base_wb_en = base_wb_req;
      if (dabt_now) begin
         if (is_swap) begin
            reg_wr_en = 1'b0;
            base_wb_en = 1'b0;
         end else if (is_block_xfer) begin
            reg_wr_en = 1'b0;
         end else if (is_single_xfer) begin
            base_wb_en = base_wb_req;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Priority selection at instruction end; in ST_CHAIN the fast entry is forced without instr_end
   cxe_cause_e take;
   always_comb begin
      take = CAUSE_NONE;
      if (instr_end) begin
         if (dabt_now) take = CAUSE_DABT;
         else if (fiq_pend) take = CAUSE_FIQ;
         else if (irq_pend) take = CAUSE_IRQ;
         else if (pabt_hit) take = CAUSE_PABT;
         else if (undef_hit) take = CAUSE_UNDEF;
         else if (trap_hit) take = CAUSE_TRAP;
      end
      if (state_r == ST_CHAIN) take = CAUSE_FIQ;
   end

   logic [2:0] bank_n;
   logic [4:0] mode_n;
   logic [31:0] link_n, vec_n;
   logic set_f;
   always_comb begin
      bank_n = BANK_FIQ;
      mode_n = MODE_FIQ;
      link_n = next_pc + ADDR_STEP;
      vec_n = VEC_FIQ;
      set_f = 1'b0;
      case (take)
         CAUSE_FIQ: begin
            set_f = 1'b1;
            if (state_r == ST_CHAIN) link_n = VEC_DABT + ADDR_STEP;
         end
         CAUSE_IRQ: begin
            bank_n = BANK_IRQ;
            mode_n = MODE_IRQ;
            vec_n = VEC_IRQ;
         end
         CAUSE_DABT: begin
            bank_n = BANK_ABT;
            mode_n = MODE_ABT;
            link_n = exec_pc + ADDR_STEP2;
            vec_n = VEC_DABT;
         end
         CAUSE_PABT: begin
            bank_n = BANK_ABT;
            mode_n = MODE_ABT;
            link_n = exec_pc + ADDR_STEP;
            vec_n = VEC_PABT;
         end
         CAUSE_TRAP: begin
            bank_n = BANK_SVC;
            mode_n = MODE_SVC;
            link_n = exec_pc + ADDR_STEP;
            vec_n = VEC_TRAP;
         end
         CAUSE_UNDEF: begin
            bank_n = BANK_UND;
            mode_n = MODE_UND;
            link_n = exec_pc + ADDR_STEP;
            vec_n = VEC_UNDEF;
         end
         default: begin
            bank_n = BANK_FIQ;
         end
      endcase
   end

   function automatic logic [2:0] bank_of(input logic [4:0] m);
      case (m)
         MODE_FIQ: bank_of = BANK_FIQ;
         MODE_IRQ: bank_of = BANK_IRQ;
         MODE_ABT: bank_of = BANK_ABT;
         MODE_UND: bank_of = BANK_UND;
         default: bank_of = BANK_SVC;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Sequencer, status word and banks
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= ST_RESET;
      end else begin
         case (state_r)
            ST_RESET: state_r <= ST_REXIT;
            ST_REXIT: state_r <= ST_RUN;
            ST_RUN: state_r <= (take == CAUSE_DABT && fiq_pend) ? ST_CHAIN : ST_RUN;
            ST_CHAIN: state_r <= ST_RUN;
            default: state_r <= ST_RUN;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         current_status_word_r <= PSR_RESET;
         cause_r <= CAUSE_RESET;
         for (int i = 0; i < 5; i++) begin
            link_r[i] <= '0;
            saved_r[i] <= '0;
         end
      end else if (state_r == ST_REXIT) begin
         link_r[BANK_SVC] <= cur_pc_r;
         saved_r[BANK_SVC] <= current_status_word_r;
         current_status_word_r[4:0] <= MODE_SVC;
         current_status_word_r[PSR_I_BIT] <= 1'b1;
         current_status_word_r[PSR_F_BIT] <= 1'b1;
      end else if (take != CAUSE_NONE) begin
         link_r[bank_n] <= link_n;
         saved_r[bank_n] <= current_status_word_r;
         current_status_word_r[4:0] <= mode_n;
         current_status_word_r[PSR_I_BIT] <= 1'b1;
         if (set_f) current_status_word_r[PSR_F_BIT] <= 1'b1;
         cause_r <= take;
      end else if (ret_restore && privileged) begin
         current_status_word_r <= saved_r[bank_of(current_status_word_r[4:0])];
      end else if (psr_wr_en) begin
         current_status_word_r[31:PSR_FLAGS_LSB] <= psr_wr_data[31:PSR_FLAGS_LSB];
         if (privileged) current_status_word_r[PSR_FLAGS_LSB-1:0] <= psr_wr_data[PSR_FLAGS_LSB-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Fetch address
   logic [31:0] fetch_n;
   always_comb begin
      fetch_redirect = 1'b0;
      fetch_n = fetch_addr_r;
      if (state_r == ST_REXIT) begin
         fetch_redirect = 1'b1;
         fetch_n = VEC_RESET;
      end else if (take != CAUSE_NONE) begin
         fetch_redirect = 1'b1;
         fetch_n = vec_n;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cur_pc_r <= '0;
      end else begin
         cur_pc_r <= exec_pc;
      end
   end

   // Idle walk starts from zero on the first reset edge
   logic rst_seen_r;
   always_ff @(posedge aclk) begin
      rst_seen_r <= !aresetn;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         if (rst_seen_r) fetch_addr_r <= fetch_addr_r + ADDR_STEP;
         else fetch_addr_r <= VEC_RESET;
      end else if (cfg_r[CFG_PROG32]) begin
         fetch_addr_r <= fetch_n;
      end else begin
         fetch_addr_r <= fetch_n & ADDR_MASK26;
      end
   end

   always_ff @(posedge aclk) begin
      bank_link_r <= (bank_sel < 3'h5) ? link_r[bank_sel] : '0;
      bank_saved_r <= (bank_sel < 3'h5) ? saved_r[bank_sel] : '0;
   end

   assign current_status_word = current_status_word_r;

   ////////////////////////////////////////////////////////////////////////
   // Configuration outputs
   assign mmu_enable = cfg_r[CFG_MMU];
   assign align_fault_enable = cfg_r[CFG_ALIGN];
   assign cache_enable = cfg_r[CFG_CACHE];
   assign wbuf_enable = cfg_r[CFG_WBUF];
   assign data_space_32 = cfg_r[CFG_DATA32];
   assign big_endian = cfg_r[CFG_BIG];
   assign tlb_flush = state_r == ST_REXIT;
   assign cache_flush = state_r == ST_REXIT;

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   logic aw_held_r, w_held_r;
   logic [ADDR_W-1:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic do_write;
   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_addr_r <= '0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end else if (do_write) begin
            w_held_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= CFG_RESET;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= RESP_OKAY;
            if (aw_addr_r[3:0] == OFF_CONFIG) begin
               for (int b = 0; b < 4; b++) begin
                  if (w_strb_r[b]) cfg_r[b*8+:8] <= w_data_r[b*8+:8] & CFG_WMASK[b*8+:8];
               end
            end else if (aw_addr_r[3:0] != OFF_STATUS && aw_addr_r[3:0] != OFF_CAUSE) begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         case (s_axi_araddr[3:0])
            OFF_CONFIG: s_axi_rdata <= cfg_r;
            OFF_STATUS: s_axi_rdata <= current_status_word_r;
            OFF_CAUSE: s_axi_rdata <= {29'h0, cause_r};
            default: begin
               s_axi_rdata <= '0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_fast_sync_delay: assert property (fast_sync_r == $past(fast_int_n))
      else $error("fast line not delayed by one clock");
   a_fast_entry: assert property (state_r == ST_RUN && instr_end && !dabt_now && fiq_pend
      |=> current_status_word_r[4:0] == MODE_FIQ && current_status_word_r[PSR_F_BIT] && current_status_word_r[PSR_I_BIT]
          && fetch_addr_r[7:0] == 8'h1C)
      else $error("fast entry wrong");
   a_masked_normal: assert property (current_status_word_r[PSR_I_BIT] && state_r == ST_RUN
      |-> take != CAUSE_IRQ)
      else $error("masked normal interrupt taken");
   a_normal_entry: assert property (take == CAUSE_IRQ |=> current_status_word_r[4:0] == MODE_IRQ
      && link_r[BANK_IRQ] == $past(next_pc) + ADDR_STEP)
      else $error("normal entry wrong");
   a_user_masks: assert property (current_status_word_r[4:0] == MODE_USR && take == CAUSE_NONE && !ret_restore
      |=> current_status_word_r[7:6] == $past(current_status_word_r[7:6]))
      else $error("user mode changed masks");
   a_swap_block: assert property (dabt_now && is_swap |-> !reg_wr_en && !base_wb_en)
      else $error("aborted swap wrote registers");
   a_block_xfer: assert property (dabt_now && is_block_xfer |-> !reg_wr_en
      && base_wb_en == base_wb_req)
      else $error("aborted block transfer gating wrong");
   a_dabt_link: assert property (take == CAUSE_DABT |=> link_r[BANK_ABT] == $past(exec_pc) + ADDR_STEP2
      && fetch_addr_r[7:0] == 8'h10)
      else $error("data abort entry wrong");
   a_chain_fast: assert property (state_r == ST_RUN && take == CAUSE_DABT && fiq_pend
      |=> take == CAUSE_FIQ ##1 current_status_word_r[4:0] == MODE_FIQ)
      else $error("fast entry did not follow data abort");
   a_reset_exit: assert property (state_r == ST_REXIT |=> current_status_word_r[4:0] == MODE_SVC
      && fetch_addr_r == VEC_RESET && current_status_word_r[7:6] == 2'h3)
      else $error("reset exit wrong");
   a_no_rsvd_vec: assert property (fetch_redirect |-> fetch_n != VEC_RSVD)
      else $error("reserved vector selected");

   c_fast: cover property (take == CAUSE_FIQ);
   c_chain: cover property (state_r == ST_CHAIN);
   c_undef: cover property (take == CAUSE_UNDEF);
   c_pabt: cover property (take == CAUSE_PABT);
endmodule

// ### src/cxe_pkg.sv
/*
 * Package for the exception entry unit: mode codes, vectors, status word
 * fields, register offsets and reset values.
 * Assumes a 32-bit core and a 32-bit AXI4-Lite register bus.
 */
package cxe_pkg;
   // Mode field codes
   localparam logic [4:0] MODE_USR = 5'h10;
   localparam logic [4:0] MODE_FIQ = 5'h11;
   localparam logic [4:0] MODE_IRQ = 5'h12;
   localparam logic [4:0] MODE_SVC = 5'h13;
   localparam logic [4:0] MODE_ABT = 5'h17;
   localparam logic [4:0] MODE_UND = 5'h1B;
   // Vectors
   localparam logic [31:0] VEC_RESET = 32'h0000_0000;
   localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
   localparam logic [31:0] VEC_TRAP = 32'h0000_0008;
   localparam logic [31:0] VEC_PABT = 32'h0000_000C;
   localparam logic [31:0] VEC_DABT = 32'h0000_0010;
   localparam logic [31:0] VEC_RSVD = 32'h0000_0014;
   localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
   localparam logic [31:0] VEC_FIQ = 32'h0000_001C;
   // Status word fields
   localparam int PSR_I_BIT = 7;
   localparam int PSR_F_BIT = 6;
   localparam int PSR_FLAGS_LSB = 28;
   localparam logic [31:0] PSR_RESET = 32'h0000_00D3;
   localparam logic [31:0] ADDR_STEP = 32'h0000_0004;
   localparam logic [31:0] ADDR_STEP2 = 32'h0000_0008;
   localparam logic [31:0] ADDR_MASK26 = 32'h03FF_FFFF;
   // Register offsets
   localparam logic [3:0] OFF_CONFIG = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_CAUSE = 4'h8;
   // Configuration bit positions
   localparam int CFG_MMU = 0;
   localparam int CFG_ALIGN = 1;
   localparam int CFG_CACHE = 2;
   localparam int CFG_WBUF = 3;
   localparam int CFG_PROG32 = 4;
   localparam int CFG_DATA32 = 5;
   localparam int CFG_BIG = 7;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK = 32'h0000_00BF;
   // Bank selectors for saved state readout
   localparam logic [2:0] BANK_FIQ = 3'h0;
   localparam logic [2:0] BANK_IRQ = 3'h1;
   localparam logic [2:0] BANK_SVC = 3'h2;
   localparam logic [2:0] BANK_ABT = 3'h3;
   localparam logic [2:0] BANK_UND = 3'h4;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Cause codes
   typedef enum logic [2:0] {
      CAUSE_NONE, CAUSE_RESET, CAUSE_DABT, CAUSE_FIQ,
      CAUSE_IRQ, CAUSE_PABT, CAUSE_UNDEF, CAUSE_TRAP
   } cxe_cause_e;
endpackage

// ### sim/cxe_int_model.sv
/* Far-side model: interrupt handler request lines.
   Assumes requests come from the bench on the core clock. */
`timescale 1ns/1ns
module cxe_int_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fast_req,
   input wire logic norm_req,
   input wire logic [1:0] lat,
   output logic fast_int_n,
   output logic normal_int_n
);
   logic [1:0] cnt_r;
   // Latency counter, prompt when lat is zero
   always_ff @(posedge aclk) begin
      if (!aresetn || !fast_req) cnt_r <= 2'h0;
      else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
   end
   assign fast_int_n = !(fast_req && cnt_r >= lat);
   assign normal_int_n = !norm_req;
endmodule

// ### sim/test_cxe_exception_entry.sv
/* Self-checking bench for the exception entry unit.
   Assumes the design asserts its own rules inline; redirects are checked via a note queue. */
`timescale 1ns/1ns
module test_cxe_exception_entry
   import cxe_pkg::*;
();
   localparam logic [31:0] PLAIN = 32'hE080_0000;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, fa, pa, pf, dab_i, ie;
   logic sx, sw, bx, pwe, ret, fr, nr, seen, rq, bq, tfl, cfl;
   logic [3:0] awaddr, araddr;
   logic [31:0] wdata, iw, epc, npc, pdata, pc, d, rv;
   logic [2:0] bsel;
   logic [1:0] lat, r;
   logic [7:0] cur;
   logic awready, wready, bvalid, arready, rvalid, fin, nin, rwe, bwe, redir, mmu, alg, cen, wbe, d32, big;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, faddr, csw, blink, bsav;
   logic [39:0] exp_q[$];
   logic [1:0] gexp [3] = '{2'b11, 2'b00, 2'b01};
   int fail_count = 0;
   int tests_run = 0;
   int cyc = 0;
   ////////////////////////////////////////////////////////////////////////////
   cxe_int_model int_u (.aclk(aclk), .aresetn(aresetn), .fast_req(fr), .norm_req(nr), .lat(lat),
      .fast_int_n(fin), .normal_int_n(nin));
   cxe_exception_entry dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fast_int_n(fin),
      .normal_int_n(nin), .fetch_abort(fa), .pipe_advance(pa), .pipe_flush(pf), .data_abort(dab_i),
      .instr_end(ie), .instr_word(iw), .exec_pc(epc), .next_pc(npc), .is_single_xfer(sx), .is_swap(sw),
      .is_block_xfer(bx), .reg_wr_req(rq), .base_wb_req(bq), .psr_wr_en(pwe), .psr_wr_data(pdata),
      .ret_restore(ret), .bank_sel(bsel), .reg_wr_en(rwe), .base_wb_en(bwe), .fetch_redirect(redir),
      .fetch_addr_r(faddr), .current_status_word(csw), .bank_link_r(blink), .bank_saved_r(bsav),
      .mmu_enable(mmu), .align_fault_enable(alg), .cache_enable(cen), .wbuf_enable(wbe),
      .data_space_32(d32), .big_endian(big), .tlb_flush(tfl), .cache_flush(cfl));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 0;
      forever #10 aclk = ~aclk;
   end
   task automatic conclude();
      $display("Checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 6000) begin
         fail_count++;
         conclude();
      end
   end
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Watcher: vector and status low byte one cycle after each redirect
   always @(negedge aclk) begin
      if (seen) begin
         if (exp_q.size() == 0) chk({8'h0, faddr}, 40'hFF_FFFF_FFFF);
         else chk({faddr, csw[7:0]}, exp_q.pop_front());
      end
      seen = (redir === 1'b1);
   end
   task automatic note(input logic [31:0] v, input logic [4:0] m, input logic f);
      cur = {1'b1, cur[6] | f, cur[5], m};
      exp_q.push_back({v, cur});
   endtask
   task automatic ei(input logic [31:0] w);
      @(posedge aclk);
      pc = $urandom & 32'h03FF_FFFC;
      epc <= pc;
      npc <= pc + ADDR_STEP;
      iw <= w;
      ie <= 1;
      @(posedge aclk) ie <= 0;
   endtask
   task automatic psr(input logic [7:0] v);
      @(posedge aclk);
      pwe <= 1;
      pdata <= {24'h0, v};
      if (cur[4:0] != MODE_USR) cur = v;
      @(posedge aclk) pwe <= 0;
      @(negedge aclk) chk({32'h0, csw[7:0]}, {32'h0, cur});
   endtask
   task automatic rtn(input logic [7:0] v);
      @(posedge aclk) ret <= 1;
      @(posedge aclk) ret <= 0;
      cur = v;
      @(negedge aclk) chk({32'h0, csw[7:0]}, {32'h0, v});
   endtask
   task automatic lnk(input logic [2:0] s, input logic [31:0] l, input logic [7:0] sv);
      @(posedge aclk) bsel <= s;
      repeat (2) @(posedge aclk);
      @(negedge aclk) chk({blink, bsav[7:0]}, {l, sv});
   endtask
   task automatic run(input int n);
      @(posedge aclk);
      iw <= PLAIN;
      ie <= 1;
      repeat (n) @(posedge aclk);
      ie <= 0;
   endtask
   task automatic dab(input int k);
      @(posedge aclk);
      pc = $urandom & 32'h03FF_FFFC;
      epc <= pc;
      iw <= PLAIN;
      {sx, sw, bx} <= 3'b100 >> k;
      r = 2'($urandom);
      {rq, bq} <= r;
      dab_i <= 1;
      ie <= 1;
      @(negedge aclk) chk({38'h0, rwe, bwe}, {38'h0, gexp[k] & r});
      @(posedge aclk) {dab_i, ie, sx, sw, bx} <= '0;
   endtask
   task automatic axw(input logic [3:0] a, input logic [31:0] dv);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, dv, 3'b111};
      while (!(aw && w)) begin
         @(posedge aclk);
         aw = aw | (awvalid & awready);
         w = w | (wvalid & wready);
         if (aw) awvalid <= 0;
         if (w) wvalid <= 0;
      end
      while (bvalid !== 1'b1) @(posedge aclk);
      bready <= 0;
      chk({38'h0, bresp}, {38'h0, RESP_OKAY});
   endtask
   task automatic axr(input logic [3:0] a);
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'b11};
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 0;
      while (rvalid !== 1'b1) @(posedge aclk);
      {r, d} = {rresp, rdata};
      rready <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, fa, pf, dab_i, ie, sx, sw, bx, pwe, ret, fr, nr, rq, bq} = '0;
      {awaddr, araddr, wdata, pdata, epc, bsel, lat, cur, seen, aresetn} = '0;
      {iw, npc, pa} = {PLAIN, 32'h4, 1'b1};
      void'($urandom(47647));
      repeat (10) @(posedge aclk);
      repeat (3) begin
         @(negedge aclk) pc = faddr;
         @(negedge aclk) chk({8'h0, faddr}, {8'h0, pc + ADDR_STEP});
      end
      note(VEC_RESET, MODE_SVC, 1'b1);
      @(posedge aclk) aresetn <= 1;
      @(posedge aclk);
      @(negedge aclk) chk({38'h0, tfl, cfl}, 40'h3);
      repeat (3) @(posedge aclk);
      chk({32'h0, tfl, cfl, mmu, alg, cen, wbe, d32, big}, 40'h0);
      rv = $urandom;
      axw(OFF_CONFIG, rv);
      axr(OFF_CONFIG);
      chk({6'h0, r, d}, {6'h0, RESP_OKAY, rv & CFG_WMASK});
      chk({34'h0, mmu, alg, cen, wbe, d32, big},
         {34'h0, rv[CFG_MMU], rv[CFG_ALIGN], rv[CFG_CACHE], rv[CFG_WBUF], rv[CFG_DATA32], rv[CFG_BIG]});
      axr(4'hC);
      chk({6'h0, r, d}, {6'h0, RESP_SLVERR, 32'h0});
      lat = 2'($urandom);
      {fr, nr} <= 2'b11;
      repeat (4) @(posedge aclk);
      ei(PLAIN);
      fr <= 0;
      psr(8'h13);
      note(VEC_IRQ, MODE_IRQ, 1'b0);
      ei(PLAIN);
      nr <= 0;
      lnk(BANK_IRQ, pc + 32'h8, 8'h13);
      rtn(8'h13);
      @(posedge aclk) {fr, lat, ie} <= 4'b1001;
      @(posedge aclk) ie <= 0;
      note(VEC_FIQ, MODE_FIQ, 1'b1);
      ei(PLAIN);
      lnk(BANK_FIQ, pc + 32'h8, 8'h13);
      fr <= 0;
      rtn(8'h13);
      psr(8'h10);
      psr(8'hD0);
      note(VEC_TRAP, MODE_SVC, 1'b0);
      ei(32'hEF00_0000);
      lnk(BANK_SVC, pc + ADDR_STEP, 8'h10);
      foreach (gexp[k]) if (k < 2) begin
         note(VEC_UNDEF, MODE_UND, 1'b0);
         ei(k ? 32'hEE00_0000 : 32'hE600_0010);
      end
      lnk(BANK_UND, pc + ADDR_STEP, 8'h9B);
      ei(32'hEE00_0F10);
      @(posedge aclk) fa <= 1;
      @(posedge aclk) {fa, pf} <= 2'b01;
      @(posedge aclk) pf <= 0;
      run(4);
      note(VEC_PABT, MODE_ABT, 1'b0);
      @(posedge aclk) fa <= 1;
      @(posedge aclk) fa <= 0;
      run(4);
      psr(8'h17);
      @(posedge aclk) fr <= 1;
      repeat (3) @(posedge aclk);
      for (int k = 0; k < 3; k++) begin
         note(VEC_DABT, MODE_ABT, 1'b0);
         if (k == 0) note(VEC_FIQ, MODE_FIQ, 1'b1);
         dab(k);
         if (k == 0) lnk(BANK_FIQ, VEC_DABT + ADDR_STEP, 8'h97);
         fr <= 0;
      end
      lnk(BANK_ABT, pc + ADDR_STEP2, 8'hD7);
      repeat (4) @(posedge aclk);
      chk({8'h0, 32'(exp_q.size())}, 40'h0);
      conclude();
   end
endmodule
